// ---- logic/ccseq_defines.vh ----
// Purpose: Constants for the channel configuration and cascade sequencer.
// Assumes: Included by bare name from the design file.
// Notes:   Field positions address the 16-bit channel configuration word.
`ifndef CCSEQ_DEFINES_VH
`define CCSEQ_DEFINES_VH
`define CCSEQ_CFG_WRITE_MASK   16'h7cff
`define CCSEQ_CFG_RESET        16'h0000
`define CCSEQ_BIT_CASCADE      14
`define CCSEQ_SEL_HI           13
`define CCSEQ_SEL_LO           12
`define CCSEQ_BIT_FAST_OFF     11
`define CCSEQ_BIT_SUP_RES      10
`define CCSEQ_BIT_CONT_TRIM    7
`define CCSEQ_BIT_RETRIM_WARN  6
`define CCSEQ_DAC_HI           5
`define CCSEQ_DAC_LO           4
`define CCSEQ_BIT_WPU          3
`define CCSEQ_BIT_WPD          2
`define CCSEQ_BIT_GAIN         1
`define CCSEQ_BIT_POL          0
`define CCSEQ_DAC_SERVO        2'h0
`define CCSEQ_DAC_OPEN         2'h1
`define CCSEQ_DAC_DIRECT       2'h2
`define CCSEQ_DAC_SOFT_WRITE   2'h3
`define CCSEQ_ST_OFF           2'h0
`define CCSEQ_ST_ON            2'h1
`define CCSEQ_ST_FAULTED       2'h2
`endif

// ---- logic/ccseq_top.v ----
// Purpose: Per-channel configuration word and cascade sequence-on control.
// Assumes: Inputs are synchronous to CLOCK; page and write strobes come from the serial front end.
// Notes:   Analog drivers are represented by select and enable outputs.
// How it works
// - Bit 15 and bits 9:8 ignore writes and read zero.
// - Cascade bit makes selected run input a sequence-on input only.
// - Bits 13:12 pick one of four run inputs.
// - Bit 11 set disables fast servo during trim or margin.
// - Bit 10 selects 4 mV or 8 mV supervisor step.
// - Continuous trim keeps servoing, only with DAC usage 00.
// - Retrim on warning, only with usage 00 and continuous clear.
// - Bits 5:4 pick DAC usage after channel on and rise elapsed.
// - Bit 3 selects weak pull-up or three-state while on.
// - Bit 2 selects weak pull-down for soft stops; faults use fast.
// - Bit 1 selects trim buffer gain.
// - Bit 0 selects trim polarity.
// - Slave start waits until its run input is high.
// - Cascade slaves still retry after faults with run input low.
// - Off then on command clears faulted-off state in cascade.
// - Broadcast shutdown raises alert and fault line event flags.
`include "ccseq_defines.vh"
`default_nettype none

module ccseq_top #(
    parameter NCH = 4
) (
    input  wire        CLOCK,
    input  wire        NRST,
    input  wire [1:0]  PAGE,
    input  wire        CFG_WR,
    input  wire [15:0] CFG_WDATA,
    output reg  [15:0] CFG_RDATA,
    input  wire [3:0]  RUN_INPUT,
    input  wire [3:0]  OP_ON,
    input  wire [3:0]  RISE_DONE,
    input  wire [3:0]  FAULT_OFF,
    input  wire [3:0]  RETRY_REQ,
    input  wire [3:0]  FAULT_LINE_RESPONSE_ENABLE,
    input  wire        SHARED_FAULT_LINE_ZERO_N,
    input  wire [3:0]  EVENT_CLEAR,
    output reg  [3:0]  FAULT_LINE_INPUT_EVENT,
    output reg         HOST_ALERT_OUTPUT_N,
    output reg  [3:0]  CHANNEL_ON,
    output reg  [3:0]  EN_PULLUP_OE,
    output reg  [3:0]  EN_WEAK_PULLUP,
    output reg  [3:0]  EN_PULLDOWN_OE,
    output reg  [3:0]  EN_WEAK_PULLDOWN,
    output reg  [3:0]  FAST_SERVO_EN,
    output reg  [3:0]  SUPERVISOR_COARSE,
    output reg  [3:0]  SERVO_CONTINUOUS,
    output reg  [3:0]  RETRIM_ON_WARN,
    output reg  [3:0]  DAC_CONNECT,
    output reg  [3:0]  DAC_SOFT_CONNECT,
    output reg  [3:0]  DAC_WRITE_ALLOWED,
    output reg  [3:0]  SERVO_ACTIVE,
    output reg  [3:0]  TRIM_GAIN_HIGH,
    output reg  [3:0]  TRIM_NONINVERT
);

    //--------------------------------------------------------------
    // Reset release
    //--------------------------------------------------------------
    // Two stages keep the release clean of metastability.
    // Reset is asserted at once but released only on a clock edge. That
    // way every register below leaves reset in the same cycle.
    // The cost is two cycles of latency after the pin is released, so the
    // first register access must wait for the third edge.
    reg [1:0] rst_sync_r;
    wire      rst_n;

    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'h1};
        end
    end

    assign rst_n = rst_sync_r[1];

    //--------------------------------------------------------------
    // Configuration storage
    //--------------------------------------------------------------
    reg [15:0] cfg_r    [0:NCH-1];
    reg [1:0]  state_r  [0:NCH-1];
    reg [NCH-1:0] op_prev_r;
    reg [NCH-1:0] soft_stop_r;
    reg        line_prev_r;
    wire       line_fall;
    integer    i;
    integer    j;
    integer    k;
    integer    n;

    // The fault line is active low and is shared by several devices.
    // Only its falling edge counts as a broadcast, so a line held low
    // does not keep forcing channels that the host has restarted.
    // The previous level resets high, which is the line's idle level,
    // so no false edge follows reset.
    assign line_fall = line_prev_r & ~SHARED_FAULT_LINE_ZERO_N;

    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            for (j = 0; j < NCH; j = j + 1) begin
                cfg_r[j] <= `CCSEQ_CFG_RESET;
            end
        end else if (CFG_WR) begin
            cfg_r[PAGE] <= CFG_WDATA & `CCSEQ_CFG_WRITE_MASK;
        end
    end

    // Read data comes from a flip-flop; reserved bits always read zero.
    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            CFG_RDATA <= 16'h0000;
        end else begin
            CFG_RDATA <= cfg_r[PAGE] & `CCSEQ_CFG_WRITE_MASK;
        end
    end

    //--------------------------------------------------------------
    // Channel sequencing
    //--------------------------------------------------------------
    // Each channel is off, on, or latched faulted off. In cascade mode the
    // command level edge lets the host clear a latched fault with an off-then-on pair.
    // A fault always wins over a soft stop in the same cycle, because the
    // fast pull-down must be used whenever a fault caused the shutdown.
    // In cascade mode the run input only starts a channel; stopping is
    // left to commands and the fault line, since power good cannot order it.
    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            for (n = 0; n < NCH; n = n + 1) begin
                state_r[n] <= `CCSEQ_ST_OFF;
            end
            op_prev_r   <= {NCH{1'b0}};
            soft_stop_r <= {NCH{1'b0}};
            line_prev_r <= 1'b1;
        end else begin
            op_prev_r   <= OP_ON;
            line_prev_r <= SHARED_FAULT_LINE_ZERO_N;
            for (n = 0; n < NCH; n = n + 1) begin
                case (state_r[n])
                    `CCSEQ_ST_OFF: begin
                        if (OP_ON[n] && RUN_INPUT[cfg_r[n][`CCSEQ_SEL_HI:`CCSEQ_SEL_LO]]) begin
                            state_r[n] <= `CCSEQ_ST_ON;
                        end
                    end
                    `CCSEQ_ST_ON: begin
                        // A fault or a broadcast shutdown latches the channel off.
                        if (FAULT_OFF[n] ||
                            (line_fall && FAULT_LINE_RESPONSE_ENABLE[n])) begin
                            state_r[n]     <= `CCSEQ_ST_FAULTED;
                            soft_stop_r[n] <= 1'b0;
                        end else if (!OP_ON[n]) begin
                            state_r[n]     <= `CCSEQ_ST_OFF;
                            soft_stop_r[n] <= 1'b1;
                        end else if (!cfg_r[n][`CCSEQ_BIT_CASCADE] &&
                                     !RUN_INPUT[cfg_r[n][`CCSEQ_SEL_HI:`CCSEQ_SEL_LO]]) begin
                            // Without cascade the run input also stops the channel.
                            state_r[n]     <= `CCSEQ_ST_OFF;
                            soft_stop_r[n] <= 1'b1;
                        end
                    end
                    `CCSEQ_ST_FAULTED: begin
                        // off-on clears fault
                        // A slave whose master is down would never restart if
                        // its retry waited on the run input, hence the bypass.
                        if (OP_ON[n] && !op_prev_r[n] && cfg_r[n][`CCSEQ_BIT_CASCADE]) begin
                            state_r[n] <= `CCSEQ_ST_ON;
                        end else if (RETRY_REQ[n] && OP_ON[n] &&
                                     (cfg_r[n][`CCSEQ_BIT_CASCADE] ||
                                      RUN_INPUT[cfg_r[n][`CCSEQ_SEL_HI:`CCSEQ_SEL_LO]])) begin
                            state_r[n] <= `CCSEQ_ST_ON;
                        end
                    end
                    default: begin
                        // An unused code returns to off rather than hang.
                        state_r[n] <= `CCSEQ_ST_OFF;
                    end
                endcase
            end
        end
    end

    //--------------------------------------------------------------
    // Fault line event flags and alert
    //--------------------------------------------------------------
    // event flags and alert
    // A set in the same cycle as a clear wins, so no shutdown is lost.
    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            FAULT_LINE_INPUT_EVENT <= 4'h0;
            HOST_ALERT_OUTPUT_N    <= 1'b1;
        end else begin
            for (k = 0; k < NCH; k = k + 1) begin
                if (line_fall && FAULT_LINE_RESPONSE_ENABLE[k]) begin
                    FAULT_LINE_INPUT_EVENT[k] <= 1'b1;
                end else if (EVENT_CLEAR[k]) begin
                    FAULT_LINE_INPUT_EVENT[k] <= 1'b0;
                end
            end
            // The alert is worked out from the next flag values, so it
            // falls with the flags and rises in the cycle they clear.
            // Only channels that respond to the line raise the alert.
            HOST_ALERT_OUTPUT_N <= ~(|(FAULT_LINE_INPUT_EVENT & ~EVENT_CLEAR) |
                                     (line_fall & |FAULT_LINE_RESPONSE_ENABLE));
        end
    end

    //--------------------------------------------------------------
    // Per-channel drive and trim controls
    // Every control is registered so that the analog side never sees a
    // glitch from the decode. The price is one cycle of delay after a
    // state change or a write.
    // The DAC controls are cleared whenever the channel is off or still
    // rising, so a mode change takes effect only once the output is up.
    // A limitation: the DAC value itself lives outside this block.
    //--------------------------------------------------------------
    always @(posedge CLOCK or negedge rst_n) begin
        if (!rst_n) begin
            CHANNEL_ON        <= 4'h0;
            EN_PULLUP_OE      <= 4'h0;
            EN_WEAK_PULLUP    <= 4'h0;
            EN_PULLDOWN_OE    <= 4'h0;
            EN_WEAK_PULLDOWN  <= 4'h0;
            FAST_SERVO_EN     <= 4'h0;
            SUPERVISOR_COARSE <= 4'h0;
            SERVO_CONTINUOUS  <= 4'h0;
            RETRIM_ON_WARN    <= 4'h0;
            DAC_CONNECT       <= 4'h0;
            DAC_SOFT_CONNECT  <= 4'h0;
            DAC_WRITE_ALLOWED <= 4'h0;
            SERVO_ACTIVE      <= 4'h0;
            TRIM_GAIN_HIGH    <= 4'h0;
            TRIM_NONINVERT    <= 4'h0;
        end else begin
            for (i = 0; i < NCH; i = i + 1) begin
                CHANNEL_ON[i] <= (state_r[i] == `CCSEQ_ST_ON);
                EN_PULLUP_OE[i]   <= (state_r[i] == `CCSEQ_ST_ON) && cfg_r[i][`CCSEQ_BIT_WPU];
                EN_WEAK_PULLUP[i] <= cfg_r[i][`CCSEQ_BIT_WPU];
                EN_PULLDOWN_OE[i]   <= (state_r[i] != `CCSEQ_ST_ON);
                EN_WEAK_PULLDOWN[i] <= (state_r[i] == `CCSEQ_ST_OFF) && soft_stop_r[i] &&
                                       cfg_r[i][`CCSEQ_BIT_WPD];
                FAST_SERVO_EN[i] <= ~cfg_r[i][`CCSEQ_BIT_FAST_OFF];
                SUPERVISOR_COARSE[i] <= cfg_r[i][`CCSEQ_BIT_SUP_RES];
                SERVO_CONTINUOUS[i] <= cfg_r[i][`CCSEQ_BIT_CONT_TRIM] &&
                                       (cfg_r[i][`CCSEQ_DAC_HI:`CCSEQ_DAC_LO] == `CCSEQ_DAC_SERVO);
                RETRIM_ON_WARN[i] <= cfg_r[i][`CCSEQ_BIT_RETRIM_WARN] && !cfg_r[i][`CCSEQ_BIT_CONT_TRIM] &&
                                     (cfg_r[i][`CCSEQ_DAC_HI:`CCSEQ_DAC_LO] == `CCSEQ_DAC_SERVO);
                // DAC usage after rise
                // The direct mode uses whatever DAC value the host last wrote.
                if ((state_r[i] == `CCSEQ_ST_ON) && RISE_DONE[i]) begin
                    DAC_CONNECT[i] <= (cfg_r[i][`CCSEQ_DAC_HI:`CCSEQ_DAC_LO] != `CCSEQ_DAC_OPEN);
                    DAC_SOFT_CONNECT[i] <= (cfg_r[i][`CCSEQ_DAC_HI:`CCSEQ_DAC_LO] == `CCSEQ_DAC_SERVO) ||
                                           (cfg_r[i][`CCSEQ_DAC_HI:`CCSEQ_DAC_LO] == `CCSEQ_DAC_SOFT_WRITE);
                    DAC_WRITE_ALLOWED[i] <= (cfg_r[i][`CCSEQ_DAC_HI:`CCSEQ_DAC_LO] == `CCSEQ_DAC_SOFT_WRITE) ||
                                            (cfg_r[i][`CCSEQ_DAC_HI:`CCSEQ_DAC_LO] == `CCSEQ_DAC_DIRECT);
                    SERVO_ACTIVE[i] <= (cfg_r[i][`CCSEQ_DAC_HI:`CCSEQ_DAC_LO] == `CCSEQ_DAC_SERVO);
                end else begin
                    DAC_CONNECT[i]       <= 1'b0;
                    DAC_SOFT_CONNECT[i]  <= 1'b0;
                    DAC_WRITE_ALLOWED[i] <= 1'b0;
                    SERVO_ACTIVE[i]      <= 1'b0;
                end
                TRIM_GAIN_HIGH[i] <= cfg_r[i][`CCSEQ_BIT_GAIN];
                TRIM_NONINVERT[i] <= cfg_r[i][`CCSEQ_BIT_POL];
            end
        end
    end

endmodule

`default_nettype wire

// ---- verification/ccseq_monitor.sv ----
// Purpose: Checks config decode and fault line alert at the top ports.
// Assumes: Decoded outputs settle three edges after a write or page change.
// Notes:   Only the selected page is observable.
`default_nettype none
module ccseq_monitor (
    input wire logic        CLOCK, NRST, CFG_WR, SHARED_FAULT_LINE_ZERO_N, HOST_ALERT_OUTPUT_N,
    input wire logic [1:0]  PAGE,
    input wire logic [15:0] CFG_RDATA,
    input wire logic [3:0]  FAULT_LINE_RESPONSE_ENABLE, FAST_SERVO_EN, TRIM_GAIN_HIGH, TRIM_NONINVERT,
    input wire logic [3:0]  SERVO_CONTINUOUS, RETRIM_ON_WARN, EN_PULLUP_OE, DAC_CONNECT,
    input wire logic [3:0]  SUPERVISOR_COARSE, EN_WEAK_PULLUP
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0]  q_r;
    logic [1:0]  pg_r;
    logic [15:0] w;
    logic        settled;
    assign w = CFG_RDATA;
    // The page must also match, since the read word lags a page change.
    assign settled = (q_r == 2'h3) && (PAGE == pg_r);
    // Quiet count, so a lagging decode right after a write is not flagged.
    always @(posedge CLOCK or negedge NRST) begin
        if (!NRST) begin
            q_r <= 2'h0;
            pg_r <= 2'h0;
        end else begin
            pg_r <= PAGE;
            q_r <= (CFG_WR || PAGE != pg_r) ? 2'h0 : (q_r == 2'h3 ? q_r : q_r + 2'h1);
        end
    end
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!NRST);
    a_reserved_read_zero: assert property (w[15] == 1'b0 && w[9:8] == 2'h0)
        else $error("reserved bits read nonzero");
    a_fast_servo_map: assert property (settled |-> FAST_SERVO_EN[PAGE] == !w[11])
        else $error("fast servo decode wrong");
    a_gain_pol_map: assert property (settled |-> {TRIM_GAIN_HIGH[PAGE], TRIM_NONINVERT[PAGE]} == w[1:0])
        else $error("trim gain or polarity wrong");
    a_servo_cont_gate: assert property (settled |-> SERVO_CONTINUOUS[PAGE] == (w[7] && w[5:4] == 2'h0))
        else $error("continuous servo gating wrong");
    a_retrim_warn_gate: assert property (settled |-> RETRIM_ON_WARN[PAGE] == (w[7:4] == 4'h4))
        else $error("retrim on warning gating wrong");
    a_pullup_needs_bit: assert property (settled && EN_PULLUP_OE[PAGE] |-> w[3])
        else $error("pull-up driven with bit clear");
    a_weak_pullup_copy: assert property (settled |-> EN_WEAK_PULLUP[PAGE] == w[3])
        else $error("weak pull-up select wrong");
    a_supervisor_step: assert property (settled |-> SUPERVISOR_COARSE[PAGE] == w[10])
        else $error("supervisor step select wrong");
    a_dac_open_idle: assert property (settled && w[5:4] == 2'h1 |-> !DAC_CONNECT[PAGE])
        else $error("unconnected DAC mode connected");
    a_line_raises_alert: assert property ($fell(SHARED_FAULT_LINE_ZERO_N) && settled
        && |FAULT_LINE_RESPONSE_ENABLE |-> ##[1:2] !HOST_ALERT_OUTPUT_N) else $error("alert missing");
endmodule
bind ccseq_top ccseq_monitor ccseq_monitor_inst (.CLOCK(CLOCK), .NRST(NRST), .CFG_WR(CFG_WR), .PAGE(PAGE),
    .SHARED_FAULT_LINE_ZERO_N(SHARED_FAULT_LINE_ZERO_N), .HOST_ALERT_OUTPUT_N(HOST_ALERT_OUTPUT_N),
    .CFG_RDATA(CFG_RDATA), .FAULT_LINE_RESPONSE_ENABLE(FAULT_LINE_RESPONSE_ENABLE), .FAST_SERVO_EN(FAST_SERVO_EN),
    .TRIM_GAIN_HIGH(TRIM_GAIN_HIGH), .TRIM_NONINVERT(TRIM_NONINVERT), .SERVO_CONTINUOUS(SERVO_CONTINUOUS),
    .RETRIM_ON_WARN(RETRIM_ON_WARN), .EN_PULLUP_OE(EN_PULLUP_OE), .DAC_CONNECT(DAC_CONNECT),
    .SUPERVISOR_COARSE(SUPERVISOR_COARSE), .EN_WEAK_PULLUP(EN_WEAK_PULLUP));
`default_nettype wire

// ---- verification/ccseq_supply_model.sv ----
// Purpose: Converter models whose power good follows enable.
// Assumes: One converter per channel, enabled by its channel-on output.
// Notes:   DLY sets how slowly a supply reports power good.
`default_nettype none
module ccseq_supply_model #(parameter int DLY = 3) (
    input  wire logic       clk,
    input  wire logic [3:0] en,
    output var  logic [3:0] pg
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt [4];
    initial pg = 4'h0;
    // Power good drops at the next clock edge after enable goes, so a chain cannot ride a stale level.
    always @(posedge clk) begin
        for (int i = 0; i < 4; i++) begin
            cnt[i] <= en[i] ? cnt[i] + 1 : 0;
            pg[i] <= en[i] && cnt[i] >= DLY;
        end
    end
endmodule
`default_nettype wire

// ---- verification/tb_ccseq_top.sv ----
// Purpose: Self-checking bench for the channel configuration sequencer.
// Assumes: Power good of supplies 0 to 2 feeds the next run input.
// Notes:   Inputs change at the falling edge only.
`default_nettype none
module tb_ccseq_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0, nrst = 1'b0, wr_en = 1'b0, master = 1'b0, line_n = 1'b1, alert_n;
    logic [1:0]  page = 2'h0;
    logic [15:0] wdata = 16'h0000, rdata;
    logic [3:0]  op_on = 4'h0, flt = 4'h0, retry = 4'h0, resp = 4'h0, evclr = 4'h0, pg, on, evt;
    logic [3:0]  pu_oe, pd_oe, wpd, dc, ds, dw, sv;
    int          mismatches = 0, total_checks = 0;
    ccseq_supply_model #(.DLY(3)) ccseq_supply_model_inst (.clk(clk), .en(on), .pg(pg));
    // power good chained into slave run inputs
    ccseq_top ccseq_top_inst (.CLOCK(clk), .NRST(nrst), .PAGE(page), .CFG_WR(wr_en), .CFG_WDATA(wdata),
        .CFG_RDATA(rdata), .RUN_INPUT({pg[2:0], master}), .OP_ON(op_on), .RISE_DONE(pg), .FAULT_OFF(flt),
        .RETRY_REQ(retry), .FAULT_LINE_RESPONSE_ENABLE(resp), .SHARED_FAULT_LINE_ZERO_N(line_n),
        .EVENT_CLEAR(evclr), .FAULT_LINE_INPUT_EVENT(evt), .HOST_ALERT_OUTPUT_N(alert_n), .CHANNEL_ON(on),
        .EN_PULLUP_OE(pu_oe), .EN_WEAK_PULLUP(), .EN_PULLDOWN_OE(pd_oe), .EN_WEAK_PULLDOWN(wpd),
        .FAST_SERVO_EN(), .SUPERVISOR_COARSE(), .SERVO_CONTINUOUS(), .RETRIM_ON_WARN(), .DAC_CONNECT(dc),
        .DAC_SOFT_CONNECT(ds), .DAC_WRITE_ALLOWED(dw), .SERVO_ACTIVE(sv), .TRIM_GAIN_HIGH(), .TRIM_NONINVERT());
    initial forever #10 clk = ~clk;
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        total_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [1:0] p, input logic [15:0] d);
        cyc(1);
        page = p;
        wdata = d;
        wr_en = 1'b1;
        cyc(1);
        wr_en = 1'b0;
    endtask
    task automatic rd(input logic [1:0] p, input logic [15:0] e);
        cyc(1);
        page = p;
        cyc(4);
        chk("config word", e, rdata);
    endtask
    // Waits a bounded time, since a stuck chain must fail rather than hang.
    task automatic wait_on(input logic [3:0] e);
        for (int i = 0; i < 40 && on !== e; i++) cyc(1);
        chk("channel on", 16'(e), 16'(on));
    endtask
    task automatic t_regs();
        logic [15:0] pat [4] = '{16'hffff, 16'h8340, 16'h5a5a, 16'h0c8c};
        for (int p = 0; p < 4; p++) rd(2'(p), 16'h0000);
        for (int p = 0; p < 4; p++) wr(2'(p), pat[p]);
        for (int p = 0; p < 4; p++) rd(2'(p), pat[p] & 16'h7cff);
    endtask
    task automatic t_dac();
        logic [3:0] dexp [4] = '{4'hd, 4'h0, 4'ha, 4'he};
        // direct mode relies on a host-written DAC value held outside this block.
        for (int u = 0; u < 4; u++) begin
            wr(2'h0, {10'h000, 2'(u), 4'h8});
            op_on = 4'h1;
            master = 1'b1;
            wait_on(4'h1);
            cyc(8);
            chk("dac use", 16'(dexp[u]), 16'({dc[0], ds[0], dw[0], sv[0]}));
            chk("pull-up", 16'h0001, 16'(pu_oe));
            op_on = 4'h0;
            cyc(4);
            chk("pull-down", 16'h0001, 16'({wpd[0], pd_oe[0]}));
        end
    endtask
    task automatic t_casc();
        master = 1'b0;
        for (int i = 0; i < 4; i++) wr(2'(i), {2'h1, 2'(i), 12'h004});
        op_on = 4'hf;
        cyc(6);
        chk("held off", 16'h0000, 16'(on));
        master = 1'b1;
        for (int i = 0; i < 40 && on[0] !== 1'b1; i++) cyc(1);
        chk("chain order", 16'h0001, 16'(on));
        wait_on(4'hf);
        chk("three-state", 16'h0000, 16'(pu_oe));
    endtask
    task automatic t_line();
        // response enabled on every slave first
        resp = 4'hf;
        // shutdown by the shared fault line
        line_n = 1'b0;
        cyc(3);
        chk("events", 16'h000f, 16'(evt));
        chk("alert", 16'h0000, 16'(alert_n));
        chk("fast pull-down", 16'h000f, 16'({wpd, pd_oe}));
        line_n = 1'b1;
        evclr = 4'hf;
        cyc(1);
        evclr = 4'h0;
        cyc(3);
        chk("alert clear", 16'h0001, 16'(alert_n));
        op_on = 4'h0;
        cyc(3);
        op_on = 4'hf;
        wait_on(4'hf);
    endtask
    task automatic t_retry();
        flt = 4'h3;
        cyc(1);
        flt = 4'h0;
        cyc(3);
        chk("faulted", 16'h000c, 16'(on));
        retry = 4'h2;
        cyc(1);
        retry = 4'h0;
        cyc(3);
        chk("retry", 16'h000e, 16'(on));
        op_on = 4'h0;
        cyc(3);
        chk("weak pull-down", 16'h000e, 16'(wpd));
    endtask
    task automatic results();
        if (mismatches == 0 && total_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        cyc(8);
        nrst = 1'b1;
        cyc(3);
        t_regs();
        t_dac();
        t_casc();
        t_line();
        t_retry();
        results();
    end
    // The tests need well under a thousand cycles.
    initial begin
        repeat (4000) @(posedge clk);
        mismatches++;
        results();
    end
endmodule
`default_nettype wire
